// ### core/mmst_core.sv
/*
  Management sideband core of a pluggable cable module: init sequencing,
  latched flags with clear-on-read and masks, dual-purpose pins and power
  mode control. Assumes software bits arrive on the system clock and
  module pins arrive asynchronously.
*/
// Summary of operation
// - Management init completes within 2000 ms of power-up or reset rise.
// - Interrupt line goes low within 200 ms of a triggering condition.
// - Reading flags clears them; interrupt releases within 500 us after.
// - Receive signal loss sets its flag and asserts interrupt within 100 ms.
// - Any flag condition, tx fault included, flags and interrupts in 200 ms.
// - Setting a mask bit stops that flag driving interrupt within 100 ms.
// - Clearing a mask bit lets that flag drive interrupt again within 100 ms.
// - Management bus answers within 2 s of power-up.
// - Data-not-ready clears and interrupt asserts within 2 s of power-up.
// - Fully functional within 2 s after a module reset rising edge.
// - Functional within 2 s; class 2+ only while low-power is low.
// - Dual-purpose input switches meaning within 100 ms.
// - Low-power input high reduces to power class 1 within 100 ms.
// - Low-power input low gives full function within 300 ms.
// - Dual-purpose output switches meaning within 100 ms.
// - Power override or power set bit high enters class 1 in 100 ms.
// - Clearing those bits gives full function within 300 ms.
// - Flags, masks and power bits are reached over the two-wire bus.
`timescale 1ns/100ps
module mmst_core #(
  parameter int INIT_TICKS  = mmst_pkg::INIT_TICKS,
  parameter int WAKE_TICKS  = mmst_pkg::WAKE_TICKS,
  parameter int TICK_CYCLES = mmst_pkg::TICK_CYCLES,
  parameter int NUM_FLAGS   = mmst_pkg::FLAG_COUNT
) (
  // Clock, reset, enable
  input  wire logic                 CLOCK_I,
  input  wire logic                 RST_N_I,
  input  wire logic                 CE_I,
  // Module pins from the host and the optics
  input  wire logic                 MODULE_RESET_N_I,
  input  wire logic                 LOW_POWER_REQUEST_I,
  input  wire logic                 RX_LOS_I,
  input  wire logic                 TX_FAULT_I,
  // Management bits written over the two-wire bus
  input  wire logic                 DUAL_IN_TRANSMIT_DISABLE_I,
  input  wire logic                 DUAL_OUT_LOS_I,
  input  wire logic                 POWER_CLASS1_I,
  input  wire logic                 POWER_OVERRIDE_I,
  input  wire logic                 POWER_SET_I,
  input  wire logic [NUM_FLAGS-1:0] FLAG_MASK_I,
  input  wire logic [NUM_FLAGS-3:0] OTHER_COND_I,
  input  wire logic                 FLAG_READ_I,
  // Open-drain interrupt / loss-of-signal pin
  output logic                      ATTENTION_OUT_N_O,
  output logic                      ATTENTION_OE_O,
  // Module state
  output logic                      TRANSMIT_DISABLE_O,
  output logic [NUM_FLAGS-1:0]      FLAGS_O,
  output logic                      READY_EVENT_O,
  output logic                      DATA_NOT_READY_O,
  output logic                      BUS_READY_O,
  output logic                      MGMT_INIT_O,
  output logic                      LOW_POWER_O,
  output logic                      FULLY_FUNCTIONAL_O
);

  localparam int MAXT = (INIT_TICKS > WAKE_TICKS) ? INIT_TICKS : WAKE_TICKS;
  localparam int TW   = $clog2(MAXT + 1);
  // Finish one tick early: the first tick may arrive up to one tick late
  localparam logic [TW-1:0] INIT_END = TW'(INIT_TICKS - 2);
  localparam logic [TW-1:0] WAKE_END = TW'(WAKE_TICKS - 2);
  localparam int INIT_LIMIT_CYC = INIT_TICKS * TICK_CYCLES;
  localparam int WAKE_LIMIT_CYC = WAKE_TICKS * TICK_CYCLES;

  typedef struct packed {
    mmst_pkg::mmst_state_t fsm;
    logic [TW-1:0]         tcnt;
    logic [NUM_FLAGS-1:0]  flags;
    logic [NUM_FLAGS-1:0]  cond_d;
    logic                  ready_evt;
    logic                  attn_n;
    logic                  oe;
    logic                  transmit_disable;
    logic                  dnr;
    logic                  bus_ready;
    logic                  init_o;
    logic                  lowp;
    logic                  full;
  } mmst_core_t;

  mmst_core_t r;
  mmst_core_t next_r;

  mmst_front_if fif ();

  mmst_front #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_front (
    .clock_i (CLOCK_I),
    .rst_n_i (RST_N_I),
    .ce_i    (CE_I),
    .fif     (fif)
  );

  assign fif.raw[mmst_pkg::PIN_RESET]  = MODULE_RESET_N_I;
  assign fif.raw[mmst_pkg::PIN_LOWP]   = LOW_POWER_REQUEST_I;
  assign fif.raw[mmst_pkg::PIN_RX_LOS] = RX_LOS_I;
  assign fif.raw[mmst_pkg::PIN_TX_FLT] = TX_FAULT_I;

  function automatic logic in_init(input mmst_pkg::mmst_state_t s);
    in_init = (s == mmst_pkg::ST_HOLD) || (s == mmst_pkg::ST_INIT);
  endfunction

  logic                 rst_pin;
  logic                 lowp_pin;
  logic                 los_pin;
  logic                 lp_need;
  logic                 live_now;
  logic [NUM_FLAGS-1:0] cond_now;
  logic [NUM_FLAGS-1:0] rise;

  assign rst_pin  = fif.clean[mmst_pkg::PIN_RESET];
  assign lowp_pin = fif.clean[mmst_pkg::PIN_LOWP];
  assign los_pin  = fif.clean[mmst_pkg::PIN_RX_LOS];
  assign cond_now = {OTHER_COND_I, fif.clean[mmst_pkg::PIN_TX_FLT], los_pin};
  assign rise     = cond_now & ~r.cond_d;
  assign live_now = rst_pin && !in_init(r.fsm);
  // Class 1 modules never need the low-power state
  assign lp_need  = ((!DUAL_IN_TRANSMIT_DISABLE_I && lowp_pin) || POWER_OVERRIDE_I ||
                     POWER_SET_I) && !POWER_CLASS1_I;

  always_comb begin
    next_r = r;
    if (CE_I) begin
      next_r.cond_d = cond_now;
      next_r.transmit_disable  = DUAL_IN_TRANSMIT_DISABLE_I && lowp_pin;
      case (r.fsm)
        mmst_pkg::ST_HOLD: begin
          next_r.tcnt = '0;
          if (rst_pin) begin
            next_r.fsm = mmst_pkg::ST_INIT;
          end
        end
        mmst_pkg::ST_INIT: begin
          if (fif.tick) begin
            if (r.tcnt >= INIT_END) begin
              next_r.tcnt      = '0;
              next_r.dnr       = 1'b0;
              next_r.bus_ready = 1'b1;
              next_r.ready_evt = 1'b1;
              next_r.fsm = lp_need ? mmst_pkg::ST_LOWP
                                   : mmst_pkg::ST_ACTIVE;
            end else begin
              next_r.tcnt = TW'(r.tcnt + 1'b1);
            end
          end
        end
        mmst_pkg::ST_ACTIVE: begin
          if (lp_need) begin
            next_r.fsm = mmst_pkg::ST_LOWP;
          end
        end
        mmst_pkg::ST_LOWP: begin
          next_r.tcnt = '0;
          if (!lp_need) begin
            next_r.fsm = mmst_pkg::ST_WAKE;
          end
        end
        mmst_pkg::ST_WAKE: begin
          if (lp_need) begin
            next_r.fsm = mmst_pkg::ST_LOWP;
          end else if (fif.tick) begin
            if (r.tcnt >= WAKE_END) begin
              next_r.fsm = mmst_pkg::ST_ACTIVE;
            end else begin
              next_r.tcnt = TW'(r.tcnt + 1'b1);
            end
          end
        end
        default: begin
          next_r.fsm = mmst_pkg::ST_HOLD;
        end
      endcase

      // Flags latch on a rising condition; a new event beats the read
      if (live_now) begin
        next_r.flags = (FLAG_READ_I ? '0 : r.flags) | rise;
        if (FLAG_READ_I && !(r.fsm == mmst_pkg::ST_INIT)) begin
          next_r.ready_evt = 1'b0;
        end
      end

      // A reset pin low for two or more cycles restarts the sequence
      if (!rst_pin) begin
        next_r.fsm       = mmst_pkg::ST_HOLD;
        next_r.tcnt      = '0;
        next_r.flags     = '0;
        next_r.ready_evt = 1'b0;
        next_r.dnr       = mmst_pkg::RST_DATA_NOT_READY;
        next_r.bus_ready = 1'b0;
      end

      // Masks act on the latched flags, so a mask change shows next cycle
      if (DUAL_OUT_LOS_I) begin
        next_r.attn_n = !los_pin;
      end else begin
        next_r.attn_n = !(|(next_r.flags & ~FLAG_MASK_I) ||
                          next_r.ready_evt);
      end
      next_r.oe     = !next_r.attn_n;
      next_r.init_o = in_init(next_r.fsm);
      next_r.lowp   = (next_r.fsm == mmst_pkg::ST_LOWP);
      next_r.full   = (next_r.fsm == mmst_pkg::ST_ACTIVE);
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      r           <= '0;
      r.fsm       <= mmst_pkg::ST_HOLD;
      r.dnr       <= mmst_pkg::RST_DATA_NOT_READY;
      r.attn_n    <= mmst_pkg::RST_ATTN_N;
      r.init_o    <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign ATTENTION_OUT_N_O  = r.attn_n;
  assign ATTENTION_OE_O     = r.oe;
  assign TRANSMIT_DISABLE_O = r.transmit_disable;
  assign FLAGS_O            = r.flags;
  assign READY_EVENT_O      = r.ready_evt;
  assign DATA_NOT_READY_O   = r.dnr;
  assign BUS_READY_O        = r.bus_ready;
  assign MGMT_INIT_O        = r.init_o;
  assign LOW_POWER_O        = r.lowp;
  assign FULLY_FUNCTIONAL_O = r.full;

  // Elapsed-cycle helpers for the long limits
  logic [31:0] init_cyc;
  logic [31:0] wake_cyc;
  logic [31:0] tick_gap;

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      init_cyc <= '0;
      wake_cyc <= '0;
      tick_gap <= '0;
    end else if (CE_I) begin
      init_cyc <= (r.fsm == mmst_pkg::ST_INIT) ? init_cyc + 32'h1 : '0;
      wake_cyc <= (r.fsm == mmst_pkg::ST_WAKE) ? wake_cyc + 32'h1 : '0;
      tick_gap <= fif.tick ? '0 : tick_gap + 32'h1;
    end
  end

  chk_init_time_bound: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (r.fsm == mmst_pkg::ST_INIT) |-> (init_cyc < 32'(INIT_LIMIT_CYC)))
    else $error("init state outlasted its limit");

  chk_reset_rise_init: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (CE_I && r.fsm == mmst_pkg::ST_HOLD && rst_pin)
    |=> (r.fsm == mmst_pkg::ST_INIT) && r.dnr && !r.bus_ready)
    else $error("reset release did not start init");

  chk_ready_on_done: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    $fell(r.init_o) |-> !r.dnr && r.ready_evt &&
                        (!r.attn_n || $past(DUAL_OUT_LOS_I)))
    else $error("init end did not clear not-ready and raise attention");

  chk_bus_ready_init: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    r.bus_ready == !r.init_o)
    else $error("bus ready disagrees with init state");

  chk_attn_on_event: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (CE_I && live_now && !DUAL_OUT_LOS_I && |(rise & ~FLAG_MASK_I))
    |=> !r.attn_n)
    else $error("attention not asserted after an unmasked event");

  chk_los_flag_set: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (CE_I && live_now && rise[mmst_pkg::FLAG_RX_LOS])
    |=> r.flags[mmst_pkg::FLAG_RX_LOS] &&
        (!r.attn_n || $past(FLAG_MASK_I[mmst_pkg::FLAG_RX_LOS])))
    else $error("loss-of-signal flag not latched");

  chk_fault_flag_set: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (CE_I && live_now && rise[mmst_pkg::FLAG_TX_FAULT])
    |=> r.flags[mmst_pkg::FLAG_TX_FAULT] &&
        (!r.attn_n || $past(FLAG_MASK_I[mmst_pkg::FLAG_TX_FAULT]) ||
         $past(DUAL_OUT_LOS_I)))
    else $error("fault flag not latched");

  chk_read_release: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (CE_I && live_now && FLAG_READ_I && rise == '0 && !DUAL_OUT_LOS_I)
    |=> r.attn_n && !r.oe && r.flags == '0)
    else $error("attention not released after clearing read");

  chk_mask_blocks: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (CE_I && live_now && !FLAG_READ_I && !DUAL_OUT_LOS_I && rise == '0 &&
     !r.ready_evt && (r.flags & ~FLAG_MASK_I) == '0)
    |=> r.attn_n && !r.oe)
    else $error("masked flag still drives attention");

  chk_mask_opens: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (CE_I && rst_pin && !FLAG_READ_I && !DUAL_OUT_LOS_I &&
     |(r.flags & ~FLAG_MASK_I)) |=> !r.attn_n ##0 r.oe)
    else $error("unmasked flag does not drive attention");

  chk_dual_in_mode: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    CE_I |=> (r.transmit_disable == ($past(DUAL_IN_TRANSMIT_DISABLE_I) && $past(lowp_pin))))
    else $error("dual input meaning not applied");

  chk_dual_out_mode: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (CE_I && DUAL_OUT_LOS_I) |=> (r.attn_n == !$past(los_pin)))
    else $error("dual output does not follow signal loss");

  chk_lowp_enter: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (CE_I && rst_pin && lp_need &&
     (r.fsm == mmst_pkg::ST_ACTIVE || r.fsm == mmst_pkg::ST_WAKE))
    |=> r.lowp && !r.full)
    else $error("low power not entered");

  chk_wake_bound: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (r.fsm == mmst_pkg::ST_WAKE) |-> (wake_cyc < 32'(WAKE_LIMIT_CYC)))
    else $error("wake from low power too slow");

  chk_class1_awake: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (CE_I && POWER_CLASS1_I && rst_pin && r.fsm == mmst_pkg::ST_ACTIVE)
    |=> r.full)
    else $error("class 1 module left full function");

  chk_tick_period: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (CE_I && fif.tick) |-> (tick_gap == 32'(TICK_CYCLES - 1)))
    else $error("local tick period wrong");

endmodule

// ### common/mmst_pkg.sv
/*
  Constants, pin indices and state encoding for the module management
  sideband block. Assumes a single 20 MHz system clock.
*/
package mmst_pkg;

  // System clock
  localparam int CLK_HZ        = 20_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

  // Local timebase tick, fine enough to resolve the release limit
  localparam int TICK_US     = 100;
  localparam int TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;

  // Timing limits, in their own units
  localparam int INIT_MAX_MS      = 2000;
  localparam int RESET_MIN_US     = 10;
  localparam int ATTN_ASSERT_MS   = 200;
  localparam int ATTN_RELEASE_US  = 500;
  localparam int LOS_ASSERT_MS    = 100;
  localparam int FLAG_ASSERT_MS   = 200;
  localparam int MASK_ON_MS       = 100;
  localparam int MASK_OFF_MS      = 100;
  localparam int BUS_READY_S      = 2;
  localparam int DATA_READY_S     = 2;
  localparam int RESET_READY_S    = 2;
  localparam int MODE_CHANGE_MS   = 100;
  localparam int LOWP_ENTER_MS    = 100;
  localparam int LOWP_EXIT_MS     = 300;
  localparam int PDOWN_ENTER_MS   = 100;
  localparam int PDOWN_EXIT_MS    = 300;

  // Derived counts; longest times round down
  localparam int RESET_MIN_CYCLES = RESET_MIN_US * 1000 / CLK_PERIOD_NS;
  localparam int INIT_TICKS       = INIT_MAX_MS * 1000 / TICK_US;
  localparam int WAKE_TICKS       = LOWP_EXIT_MS * 1000 / TICK_US;

  // Pin positions in the synchroniser bank
  localparam int PIN_COUNT   = 4;
  localparam int PIN_RESET   = 0;
  localparam int PIN_LOWP    = 1;
  localparam int PIN_RX_LOS  = 2;
  localparam int PIN_TX_FLT  = 3;

  // Flag positions
  localparam int FLAG_RX_LOS   = 0;
  localparam int FLAG_TX_FAULT = 1;
  localparam int FLAG_COUNT    = 8;

  // Reset values
  localparam logic RST_DATA_NOT_READY = 1'b1;
  localparam logic RST_ATTN_N         = 1'b1;

  typedef enum logic [2:0] {
    ST_HOLD   = 3'b000,
    ST_INIT   = 3'b001,
    ST_ACTIVE = 3'b011,
    ST_LOWP   = 3'b010,
    ST_WAKE   = 3'b110
  } mmst_state_t;

endpackage

// ### common/mmst_front_if.sv
/*
  Carrier between the sideband core and its pin front end.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface mmst_front_if;
  logic [mmst_pkg::PIN_COUNT-1:0] raw;
  logic [mmst_pkg::PIN_COUNT-1:0] clean;
  logic                           tick;

  modport front (input raw, output clean, output tick);
  modport core  (output raw, input clean, input tick);
endinterface

// ### core/mmst_front.sv
/*
  Pin front end: three-stage synchronisers with agreement filter and the
  fixed-rate local tick. Assumes raw pins are asynchronous to the clock.
*/
`timescale 1ns/100ps
module mmst_front #(
  parameter int TICK_CYCLES = mmst_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        ce_i,
  // Pins in, clean levels out
  mmst_front_if.front     fif
);

  localparam int NP = mmst_pkg::PIN_COUNT;
  localparam int CW = $clog2(TICK_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [NP-1:0] s1;
    logic [NP-1:0] s2;
    logic [NP-1:0] s3;
    logic [NP-1:0] clean;
    logic [CW-1:0] cnt;
  } mmst_front_t;

  mmst_front_t r;
  mmst_front_t next_r;

  always_comb begin
    next_r = r;
    if (ce_i) begin
      next_r.s1 = fif.raw;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      // A change counts only once the last two stages agree
      for (int i = 0; i < NP; i++) begin
        if (r.s2[i] == r.s3[i]) begin
          next_r.clean[i] = r.s3[i];
        end
      end
      next_r.cnt = (r.cnt == LAST) ? '0 : CW'(r.cnt + 1'b1);
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign fif.clean = r.clean;
  assign fif.tick  = (r.cnt == LAST);

endmodule

// ### testbench/mmst_host_model.sv
/*
  Host controller model: drives the module reset pin, the dual-purpose
  low-power pin and the one-cycle flag read strobe.
  Assumes the core samples everything on the rising clock edge.
*/
`timescale 1ns/100ps
module mmst_host_model (
  // Clock
  input  wire logic clock_i,
  // Host-driven pins and management read strobe
  output logic      module_reset_n_o,
  output logic      low_power_request_o,
  output logic      flag_read_o
);
  initial begin
    module_reset_n_o    = 1'b1;
    low_power_request_o = 1'b0;
    flag_read_o         = 1'b0;
  end

  // Always the full minimum width; shorter pulses may be ignored
  task automatic reset_module();
    @(posedge clock_i);
    module_reset_n_o <= 1'b0;
    repeat (mmst_pkg::RESET_MIN_CYCLES) @(posedge clock_i);
    module_reset_n_o <= 1'b1;
  endtask

  // Flag byte read over the management bus, seen as one strobe
  task automatic read_flags();
    @(posedge clock_i);
    flag_read_o <= 1'b1;
    @(posedge clock_i);
    flag_read_o <= 1'b0;
  endtask

  task automatic set_low_power(input logic v);
    @(posedge clock_i);
    low_power_request_o <= v;
  endtask
endmodule

// ### testbench/mmst_tb_top.sv
/*
  Self-checking testbench for the management sideband core.
  Assumes shortened tick and init/wake counts; host pins come from the
  host model, optics conditions and management bits from the bench.
*/
`timescale 1ns/100ps
module mmst_tb_top;
  localparam int TCK      = 8;
  localparam int INIT     = 4;
  localparam int WAKE     = 3;
  localparam int INIT_LIM = (INIT + 2) * TCK + 16;
  localparam int WAKE_LIM = (WAKE + 2) * TCK + 16;

  logic       clock;
  logic       rst_n;
  logic       ce;
  logic       rx_los;
  logic       tx_fault;
  logic       dual_in_transmit_disable;
  logic       dual_out_los;
  logic       class1;
  logic       override;
  logic       power_set;
  logic [7:0] mask;
  logic [5:0] other;
  wire logic  module_reset_n;
  wire logic  low_power_request;
  wire logic  flag_read;
  logic       attn_n;
  logic       attn_oe;
  logic       tx_disable;
  logic [7:0] flags;
  logic       ready_event;
  logic       data_not_ready;
  logic       bus_ready;
  logic       mgmt_init;
  logic       low_power;
  logic       fully_functional;
  int         error_cnt;
  int         tests_run;

  initial clock = 1'b0;
  always #(mmst_pkg::CLK_PERIOD_NS / 2) clock = ~clock;

  mmst_host_model host (
    .clock_i             (clock),
    .module_reset_n_o    (module_reset_n),
    .low_power_request_o (low_power_request),
    .flag_read_o         (flag_read)
  );

  mmst_core #(
    .INIT_TICKS  (INIT),
    .WAKE_TICKS  (WAKE),
    .TICK_CYCLES (TCK),
    .NUM_FLAGS   (8)
  ) i_dut (
    .CLOCK_I             (clock),
    .RST_N_I             (rst_n),
    .CE_I                (ce),
    .MODULE_RESET_N_I    (module_reset_n),
    .LOW_POWER_REQUEST_I (low_power_request),
    .RX_LOS_I            (rx_los),
    .TX_FAULT_I          (tx_fault),
    .DUAL_IN_TRANSMIT_DISABLE_I     (dual_in_transmit_disable),
    .DUAL_OUT_LOS_I      (dual_out_los),
    .POWER_CLASS1_I      (class1),
    .POWER_OVERRIDE_I    (override),
    .POWER_SET_I         (power_set),
    .FLAG_MASK_I         (mask),
    .OTHER_COND_I        (other),
    .FLAG_READ_I         (flag_read),
    .ATTENTION_OUT_N_O   (attn_n),
    .ATTENTION_OE_O      (attn_oe),
    .TRANSMIT_DISABLE_O  (tx_disable),
    .FLAGS_O             (flags),
    .READY_EVENT_O       (ready_event),
    .DATA_NOT_READY_O    (data_not_ready),
    .BUS_READY_O         (bus_ready),
    .MGMT_INIT_O         (mgmt_init),
    .LOW_POWER_O         (low_power),
    .FULLY_FUNCTIONAL_O  (fully_functional)
  );

  // Sample on the falling edge so the rising edge updates have landed
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_ff(input int lim);
    int n;
    n = 0;
    while (fully_functional !== 1'b1 && n < lim) begin
      @(posedge clock);
      n++;
    end
    @(negedge clock);
  endtask

  // Index 0 is receive loss, 1 transmit fault, the rest other conditions
  task automatic set_cond(input int i, input logic v);
    @(posedge clock);
    if (i == 0) rx_los <= v;
    else if (i == 1) tx_fault <= v;
    else other[i-2] <= v;
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Whole run is a few hundred cycles; this only cuts a hang short
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    end_sim();
  end

  initial begin
    error_cnt     = 0;
    tests_run     = 0;
    rst_n         = 1'b0;
    ce            = 1'b1;
    rx_los        = 1'b0;
    tx_fault      = 1'b0;
    dual_in_transmit_disable = 1'b0;
    dual_out_los  = 1'b0;
    class1        = 1'b0;
    override      = 1'b0;
    power_set     = 1'b0;
    mask          = 8'h00;
    other         = 6'h00;
    step(8);
    chk({attn_n, attn_oe}, 2'h2);
    chk(data_not_ready, 1'h1);
    chk(bus_ready, 1'h0);
    chk(mgmt_init, 1'h1);
    @(posedge clock);
    rst_n <= 1'b1;
    wait_ff(INIT_LIM);
    chk({mgmt_init, fully_functional}, 2'h1);
    chk(data_not_ready, 1'h0);
    chk(bus_ready, 1'h1);
    chk({attn_n, attn_oe}, 2'h1);
    chk(ready_event, 1'h1);
    host.read_flags();
    step(0);
    chk({ready_event, attn_n, attn_oe}, 3'h2);
    // Each flag source in turn, read while its condition still stands
    for (int i = 0; i < 8; i++) begin
      set_cond(i, 1'b1);
      step(8);
      chk(flags, 8'h01 << i);
      chk({attn_n, attn_oe}, 2'h1);
      host.read_flags();
      step(0);
      chk(flags, 8'h00);
      chk({attn_n, attn_oe}, 2'h2);
      set_cond(i, 1'b0);
    end
    @(posedge clock);
    mask <= 8'h02;
    set_cond(1, 1'b1);
    step(8);
    chk(flags, 8'h02);
    chk({attn_n, attn_oe}, 2'h2);
    @(posedge clock);
    mask <= 8'h00;
    step(2);
    chk({attn_n, attn_oe}, 2'h1);
    @(posedge clock);
    mask <= 8'h02;
    step(2);
    chk({attn_n, attn_oe}, 2'h2);
    host.read_flags();
    set_cond(1, 1'b0);
    mask <= 8'h00;
    // Loss meaning shows the live condition, untouched by a read
    @(posedge clock);
    dual_out_los <= 1'b1;
    step(2);
    chk({attn_n, attn_oe}, 2'h2);
    set_cond(0, 1'b1);
    step(8);
    chk({attn_n, attn_oe}, 2'h1);
    host.read_flags();
    step(0);
    chk({attn_n, attn_oe}, 2'h1);
    set_cond(0, 1'b0);
    step(8);
    chk({attn_n, attn_oe}, 2'h2);
    @(posedge clock);
    dual_out_los <= 1'b0;
    host.set_low_power(1'b1);
    step(8);
    chk({low_power, fully_functional}, 2'h2);
    @(posedge clock);
    dual_in_transmit_disable <= 1'b1;
    step(2);
    chk({tx_disable, low_power}, 2'h2);
    wait_ff(WAKE_LIM);
    chk(fully_functional, 1'h1);
    @(posedge clock);
    dual_in_transmit_disable <= 1'b0;
    step(2);
    chk({tx_disable, low_power}, 2'h1);
    host.set_low_power(1'b0);
    // The pin passes the synchroniser before the state can change
    step(6);
    chk({low_power, fully_functional}, 2'h0);
    wait_ff(WAKE_LIM);
    chk(fully_functional, 1'h1);
    for (int j = 0; j < 2; j++) begin
      @(posedge clock);
      override  <= (j == 0);
      power_set <= (j == 1);
      step(2);
      chk({low_power, fully_functional}, 2'h2);
      @(posedge clock);
      override  <= 1'b0;
      power_set <= 1'b0;
      wait_ff(WAKE_LIM);
      chk({low_power, fully_functional}, 2'h1);
    end
    @(posedge clock);
    class1    <= 1'b1;
    power_set <= 1'b1;
    step(4);
    chk({low_power, fully_functional}, 2'h1);
    @(posedge clock);
    class1    <= 1'b0;
    power_set <= 1'b0;
    // With the enable low an event waits, then latches on the first live edge
    @(posedge clock);
    ce <= 1'b0;
    set_cond(3, 1'b1);
    step(4);
    chk(flags, 8'h00);
    chk({attn_n, attn_oe}, 2'h2);
    @(posedge clock);
    ce <= 1'b1;
    step(1);
    chk(flags, 8'h08);
    chk({attn_n, attn_oe}, 2'h1);
    set_cond(3, 1'b0);
    // A pending flag must be wiped by the module reset
    set_cond(2, 1'b1);
    set_cond(2, 1'b0);
    host.reset_module();
    step(0);
    chk({mgmt_init, data_not_ready, bus_ready}, 3'h6);
    chk(flags, 8'h00);
    wait_ff(INIT_LIM);
    chk({mgmt_init, ready_event, fully_functional}, 3'h3);
    end_sim();
  end
endmodule
